// ==== src/pts_defs.svh ====
// constants for the two-wire potentiometer slave and its bus master
`ifndef PTS_DEFS_SVH
`define PTS_DEFS_SVH

`define PTS_CLK_MHZ 200
`define PTS_CLK_PERIOD_NS 5
`define PTS_SCL_PERIOD_NS 80
`define PTS_NV_WRITE_US 5000
`define PTS_NV_WRITE_MAX_US 10000

`define PTS_WIPER_W 10
`define PTS_SLOT_INIT 10'h000
`define PTS_DEFAULT_SLOT 2'h0

// opcodes, paired with the direction bit of the identification byte
`define PTS_OP_WIPER_RD 3'h4
`define PTS_OP_WIPER_WR 3'h5
`define PTS_OP_SLOT_RD 3'h5
`define PTS_OP_SLOT_WR 3'h6
`define PTS_OP_XFR_TO_WIPER 3'h6
`define PTS_OP_XFR_TO_SLOT 3'h7

// master register map
`define PTS_REG_ID 8'h00
`define PTS_REG_CMD 8'h04
`define PTS_REG_WDATA 8'h08
`define PTS_REG_CTRL 8'h0C
`define PTS_REG_STATUS 8'h10
`define PTS_REG_RDATA 8'h14
`define PTS_CTRL_GO 0
`define PTS_CTRL_POLL 1
`define PTS_CTRL_DATA 2
`define PTS_STAT_BUSY 0
`define PTS_STAT_NACK 1

`endif

// ==== src/pts_pkg.sv ====
// types shared by the potentiometer slave and its bus master
package pts_pkg;
  typedef enum logic [4:0] {
    DS_IDLE = 5'b00001,
    DS_RX = 5'b00010,
    DS_RXACK = 5'b00100,
    DS_TX = 5'b01000,
    DS_TXACK = 5'b10000
  } pts_dstate_t;

  typedef enum logic [3:0] {
    MS_IDLE = 4'b0001,
    MS_START = 4'b0010,
    MS_BIT = 4'b0100,
    MS_STOP = 4'b1000
  } pts_mstate_t;
endpackage : pts_pkg

// ==== src/pts_bus_if.sv ====
// two-wire bus joining the master and the potentiometer slave
`timescale 1ns/1ps
`default_nettype none
interface pts_bus_if;
  logic m_scl;
  logic m_sda_o;
  logic m_sda_oe;
  logic d_sda_o;
  logic d_sda_oe;
  wire scl;
  wire sda;
  // pull-up: the line is low only while someone drives a low
  assign scl = m_scl;
  assign sda = ~((m_sda_oe & ~m_sda_o) | (d_sda_oe & ~d_sda_o));
  modport dev (input scl, input sda, output d_sda_o, output d_sda_oe);
  modport mst (input sda, output m_scl, output m_sda_o, output m_sda_oe);
endinterface : pts_bus_if
`default_nettype wire

// ==== src/pts_mst.sv ====
// two-wire bus master driven by a small register port
`timescale 1ns/1ps
`default_nettype none
`include "pts_defs.svh"
module pts_mst #(
  parameter int QTR = `PTS_SCL_PERIOD_NS / (4 * `PTS_CLK_PERIOD_NS)
) (
  // clock and reset
  input wire logic CLOCK,
  input wire logic RESET,
  // register port
  input wire logic [7:0] ADDR,
  input wire logic [31:0] WDATA,
  input wire logic WSTROBE,
  input wire logic RSTROBE,
  output logic [31:0] RDATA,
  // bus
  pts_bus_if.mst BUS
);
  pts_pkg::pts_mstate_t st, next_st;
  logic [1:0] ph, next_ph;
  logic [7:0] tcnt, next_tcnt;
  logic [3:0] bitn, next_bitn;
  logic [2:0] k, next_k;
  logic [2:0] nb, next_nb;
  logic scl, next_scl;
  logic oe, next_oe;
  logic nack, next_nack;
  logic [7:0] sh, next_sh;
  logic [9:0] rd, next_rd;
  logic [7:0] id, next_id;
  logic [7:0] cmd, next_cmd;
  logic [9:0] wd, next_wd;
  logic [31:0] rdata, next_rdata;
  logic sda_m, sda_s;
  logic tick;

  function automatic logic [7:0] tx_byte(input logic [2:0] kk,
      input logic [7:0] i, input logic [7:0] c, input logic [9:0] w);
    case (kk)
      3'h0: tx_byte = i;
      3'h1: tx_byte = c;
      3'h2: tx_byte = w[7:0];
      default: tx_byte = {6'h00, w[9:8]};
    endcase
  endfunction : tx_byte

  // open-drain enable for a slot: data bit 0..7 or ack slot 8
  function automatic logic drive(input logic [2:0] kk, input logic [3:0] b,
      input logic [2:0] n, input logic [7:0] i, input logic [7:0] c,
      input logic [9:0] w);
    logic rx;
    logic [7:0] t;
    rx = i[0] && (kk >= 3'h2);
    t = tx_byte(kk, i, c, w);
    if (b < 4'h8) begin
      drive = rx ? 1'b0 : ~t[3'(4'h7 - b)];
    end else begin
      drive = rx ? (kk != 3'(n - 3'h1)) : 1'b0;
    end
  endfunction : drive

  assign tick = (tcnt == 8'(QTR - 1));

  always_comb begin
    next_st = st;
    next_ph = ph;
    next_tcnt = (st == pts_pkg::MS_IDLE || tick) ? 8'h00 : tcnt + 8'h01;
    next_bitn = bitn;
    next_k = k;
    next_nb = nb;
    next_scl = scl;
    next_oe = oe;
    next_nack = nack;
    next_sh = sh;
    next_rd = rd;
    next_id = id;
    next_cmd = cmd;
    next_wd = wd;
    next_rdata = 32'h0000_0000;
    if (RSTROBE) begin
      if (ADDR == `PTS_REG_ID) begin
        next_rdata = {24'h00_0000, id};
      end else if (ADDR == `PTS_REG_CMD) begin
        next_rdata = {24'h00_0000, cmd};
      end else if (ADDR == `PTS_REG_WDATA) begin
        next_rdata = {22'h00_0000, wd};
      end else if (ADDR == `PTS_REG_STATUS) begin
        next_rdata = {30'h0000_0000, nack, st != pts_pkg::MS_IDLE};
      end else if (ADDR == `PTS_REG_RDATA) begin
        next_rdata = {22'h00_0000, rd};
      end
    end
    if (WSTROBE && st == pts_pkg::MS_IDLE) begin
      if (ADDR == `PTS_REG_ID) begin
        next_id = WDATA[7:0];
      end else if (ADDR == `PTS_REG_CMD) begin
        next_cmd = WDATA[7:0];
      end else if (ADDR == `PTS_REG_WDATA) begin
        next_wd = WDATA[9:0];
      end else if (ADDR == `PTS_REG_CTRL && WDATA[`PTS_CTRL_GO]) begin
        next_st = pts_pkg::MS_START;
        next_ph = 2'h0;
        next_nack = 1'b0;
        next_k = 3'h0;
        next_bitn = 4'h0;
        next_nb = WDATA[`PTS_CTRL_POLL] ? 3'h1
                : (WDATA[`PTS_CTRL_DATA] ? 3'h4 : 3'h2);
      end
    end
    if (tick && st != pts_pkg::MS_IDLE) begin
      next_ph = ph + 2'h1;
      case (st)
        pts_pkg::MS_START: begin
          if (ph == 2'h0) next_oe = 1'b1;
          if (ph == 2'h2) next_scl = 1'b0;
          if (ph == 2'h3) begin
            next_st = pts_pkg::MS_BIT;
            next_oe = drive(3'h0, 4'h0, nb, id, cmd, wd);
          end
        end
        pts_pkg::MS_BIT: begin
          if (ph == 2'h0) next_scl = 1'b1;
          if (ph == 2'h1) begin
            // the ack slot must not shift into the received byte
            if (bitn < 4'h8) next_sh = {sh[6:0], sda_s};
            if (bitn == 4'h8 && !(id[0] && k >= 3'h2) && sda_s) begin
              next_nack = 1'b1;
            end
          end
          if (ph == 2'h2) next_scl = 1'b0;
          if (ph == 2'h3) begin
            if (bitn < 4'h8) begin
              next_bitn = bitn + 4'h1;
              next_oe = drive(k, next_bitn, nb, id, cmd, wd);
            end else begin
              if (id[0] && k == 3'h2) next_rd[7:0] = sh;
              if (id[0] && k == 3'h3) next_rd[9:8] = sh[1:0];
              if (nack || k == 3'(nb - 3'h1)) begin
                next_st = pts_pkg::MS_STOP;
                next_oe = 1'b1;
              end else begin
                next_k = k + 3'h1;
                next_bitn = 4'h0;
                next_oe = drive(next_k, 4'h0, nb, id, cmd, wd);
              end
            end
          end
        end
        pts_pkg::MS_STOP: begin
          if (ph == 2'h0) next_scl = 1'b1;
          if (ph == 2'h2) next_oe = 1'b0;
          if (ph == 2'h3) next_st = pts_pkg::MS_IDLE;
        end
        default: next_st = pts_pkg::MS_IDLE;
      endcase
    end
  end

  always_ff @(posedge CLOCK) begin
    sda_m <= BUS.sda;
    sda_s <= sda_m;
    if (RESET) begin
      st <= pts_pkg::MS_IDLE;
      ph <= 2'h0;
      tcnt <= 8'h00;
      bitn <= 4'h0;
      k <= 3'h0;
      nb <= 3'h0;
      scl <= 1'b1;
      oe <= 1'b0;
      nack <= 1'b0;
      sh <= 8'h00;
      rd <= 10'h000;
      id <= 8'h00;
      cmd <= 8'h00;
      wd <= 10'h000;
      rdata <= 32'h0000_0000;
    end else begin
      st <= next_st;
      ph <= next_ph;
      tcnt <= next_tcnt;
      bitn <= next_bitn;
      k <= next_k;
      nb <= next_nb;
      scl <= next_scl;
      oe <= next_oe;
      nack <= next_nack;
      sh <= next_sh;
      rd <= next_rd;
      id <= next_id;
      cmd <= next_cmd;
      wd <= next_wd;
      rdata <= next_rdata;
    end
  end

  assign RDATA = rdata;
  assign BUS.m_scl = scl;
  assign BUS.m_sda_o = 1'b0;
  assign BUS.m_sda_oe = oe;
endmodule : pts_mst
`default_nettype wire

// ==== src/pts_dev.sv ====
// two-wire slave and wiper logic of the 1024-tap potentiometer
`timescale 1ns/1ps
`default_nettype none
`include "pts_defs.svh"
// Notes on behaviour
// - sample on SCL rise, drive after fall
// - SDA only pulled low or released
// - strap pins give address low bits
// - at most four devices per bus
// - guard low blocks nonvolatile writes
// - wiper decodes to exactly one tap
// - reset loads wiper from default slot
// - slave only; master makes the clock
// - SDA changes only while SCL low
// - start is SDA fall, SCL high
// - master ends with a stop
// - ninth clock carries receiver acknowledge
// - ack address, command and data bytes
// - stop after NV write starts write cycle
// - no address ack while write runs
// - master polls until acknowledged; pts_mst sends one poll frame per GO write and the bench waits on NV_BUSY
// - wiper and slots readable and writable
// - id byte: type, address, direction
// - command byte: opcode, slot, zeros
// - NV write completes within 10 ms
module pts_dev #(
  parameter logic [3:0] DEV_TYPE = 4'hA, // arbitrary value
  parameter int NV_CYC = `PTS_NV_WRITE_US * `PTS_CLK_MHZ,
  parameter int WW = `PTS_WIPER_W
) (
  // clock and reset
  input wire logic CLOCK,
  input wire logic RESET,
  // straps and guard
  input wire logic [1:0] ADDR_STRAP_PINS,
  input wire logic WRITE_GUARD_N,
  // wiper
  output logic [(1 << WW) - 1:0] TAP_SEL,
  output logic [WW - 1:0] WIPER_POS,
  output logic NV_BUSY,
  // bus
  pts_bus_if.dev BUS
);
  localparam int NVW = $clog2(NV_CYC + 1);

  pts_pkg::pts_dstate_t st, next_st;
  logic [3:0] cnt, next_cnt;
  logic [2:0] byte_idx, next_byte_idx;
  logic [7:0] sh, next_sh;
  logic rw, next_rw;
  logic [2:0] op, next_op;
  logic [1:0] sel, next_sel;
  logic [7:0] hold, next_hold;
  logic oe, next_oe;
  logic [WW - 1:0] wiper_position_reg, next_wiper;
  logic [(1 << WW) - 1:0] tap, next_tap;
  logic pend, next_pend;
  logic busy, next_busy;
  logic [NVW - 1:0] nv_cnt, next_nv_cnt;
  logic [WW - 1:0] nv_data, next_nv_data;
  logic [1:0] nv_sel, next_nv_sel;
  logic commit;
  // nonvolatile: RESET leaves it alone, blank at power-up
  logic [WW - 1:0] slots [0:3] = '{default: `PTS_SLOT_INIT};
  logic scl_m, scl_s, scl_p, sda_m, sda_s, sda_p;
  logic [1:0] strap_m, strap_s;
  logic guard_m, guard_s;
  logic rise, fall, start, stop;
  logic [WW - 1:0] rd_val;

  function automatic logic legal(input logic r, input logic [2:0] o);
    legal = r ? (o == `PTS_OP_WIPER_RD || o == `PTS_OP_SLOT_RD
                 || o == `PTS_OP_XFR_TO_WIPER)
              : (o == `PTS_OP_WIPER_WR || o == `PTS_OP_SLOT_WR
                 || o == `PTS_OP_XFR_TO_SLOT);
  endfunction : legal

  function automatic logic has_data(input logic r, input logic [2:0] o);
    has_data = r ? (o == `PTS_OP_WIPER_RD || o == `PTS_OP_SLOT_RD)
                 : (o == `PTS_OP_WIPER_WR || o == `PTS_OP_SLOT_WR);
  endfunction : has_data

  function automatic logic [(1 << WW) - 1:0] onehot(input logic [WW - 1:0] v);
    onehot = '0;
    onehot[v] = 1'b1;
  endfunction : onehot

  // edges come from the synchronised lines; first stages feed nothing else
  assign rise = scl_s & ~scl_p;
  assign fall = ~scl_s & scl_p;
  assign start = scl_s & scl_p & sda_p & ~sda_s;
  assign stop = scl_s & scl_p & ~sda_p & sda_s;
  assign rd_val = (op == `PTS_OP_WIPER_RD) ? wiper_position_reg : slots[sel];

  always_comb begin
    next_st = st;
    next_cnt = cnt;
    next_byte_idx = byte_idx;
    next_sh = sh;
    next_rw = rw;
    next_op = op;
    next_sel = sel;
    next_hold = hold;
    next_oe = oe;
    next_wiper = wiper_position_reg;
    next_pend = pend;
    next_busy = busy;
    next_nv_cnt = nv_cnt;
    next_nv_data = nv_data;
    next_nv_sel = nv_sel;
    commit = 1'b0;
    // write cycle is the typical time, inside the 10 ms bound
    if (busy) begin
      next_nv_cnt = nv_cnt - NVW'(1);
      if (nv_cnt == NVW'(1)) begin
        next_busy = 1'b0;
        commit = 1'b1;
      end
    end
    if (start) begin
      next_st = pts_pkg::DS_RX;
      next_cnt = 4'h0;
      next_byte_idx = 3'h0;
      next_oe = 1'b0;
    end else if (stop) begin
      next_st = pts_pkg::DS_IDLE;
      next_oe = 1'b0;
      if (pend && !busy) begin
        next_pend = 1'b0;
        next_busy = 1'b1;
        next_nv_cnt = NVW'(NV_CYC);
      end
    end else begin
      case (st)
        pts_pkg::DS_RX: begin
          if (rise) begin
            next_sh = {sh[6:0], sda_s};
            next_cnt = cnt + 4'h1;
          end
          if (fall && cnt == 4'h8) begin
            next_st = pts_pkg::DS_IDLE;
            case (byte_idx)
              3'h0: begin
                next_rw = sh[0];
                if (sh[7:4] == DEV_TYPE && !sh[3]
                    && sh[2:1] == strap_s && !busy) begin
                  next_st = pts_pkg::DS_RXACK;
                end
              end
              3'h1: begin
                next_op = sh[7:5];
                next_sel = sh[3:2];
                if (!sh[4] && sh[1:0] == 2'h0 && legal(rw, sh[7:5])) begin
                  next_st = pts_pkg::DS_RXACK;
                  if (rw && sh[7:5] == `PTS_OP_XFR_TO_WIPER) begin
                    next_wiper = slots[sh[3:2]];
                  end
                  if (!rw && sh[7:5] == `PTS_OP_XFR_TO_SLOT && guard_s) begin
                    next_pend = 1'b1;
                    next_nv_data = wiper_position_reg;
                    next_nv_sel = sh[3:2];
                  end
                end
              end
              3'h2: begin
                next_hold = sh;
                next_st = pts_pkg::DS_RXACK;
              end
              3'h3: begin
                next_st = pts_pkg::DS_RXACK;
                if (op == `PTS_OP_WIPER_WR) begin
                  next_wiper = {sh[1:0], hold};
                end else if (guard_s) begin
                  next_pend = 1'b1;
                  next_nv_data = {sh[1:0], hold};
                  next_nv_sel = sel;
                end
              end
              default: next_st = pts_pkg::DS_IDLE;
            endcase
            next_oe = next_st == pts_pkg::DS_RXACK;
          end
        end
        pts_pkg::DS_RXACK: begin
          if (fall) begin
            next_oe = 1'b0;
            next_cnt = 4'h0;
            next_byte_idx = byte_idx + 3'h1;
            if (byte_idx == 3'h0) begin
              next_st = pts_pkg::DS_RX;
            end else if (byte_idx == 3'h1 && has_data(rw, op)) begin
              if (rw) begin
                next_st = pts_pkg::DS_TX;
                next_sh = rd_val[7:0];
                next_oe = ~rd_val[7];
              end else begin
                next_st = pts_pkg::DS_RX;
              end
            end else if (byte_idx == 3'h2) begin
              next_st = pts_pkg::DS_RX;
            end else begin
              next_st = pts_pkg::DS_IDLE;
            end
          end
        end
        pts_pkg::DS_TX: begin
          if (rise) next_cnt = cnt + 4'h1;
          if (fall) begin
            if (cnt == 4'h8) begin
              next_oe = 1'b0;
              next_st = pts_pkg::DS_TXACK;
            end else begin
              next_sh = {sh[6:0], 1'b0};
              next_oe = ~sh[6];
            end
          end
        end
        pts_pkg::DS_TXACK: begin
          // a master nack ends the read; device waits for the stop
          if (rise && sda_s) next_st = pts_pkg::DS_IDLE;
          if (fall) begin
            if (byte_idx == 3'h2) begin
              next_byte_idx = 3'h3;
              next_cnt = 4'h0;
              next_st = pts_pkg::DS_TX;
              next_sh = {6'h00, rd_val[9:8]};
              next_oe = 1'b1;
            end else begin
              next_st = pts_pkg::DS_IDLE;
            end
          end
        end
        default: next_st = pts_pkg::DS_IDLE;
      endcase
    end
    next_tap = onehot(next_wiper);
  end

  always_ff @(posedge CLOCK) begin
    scl_m <= BUS.scl;
    scl_s <= scl_m;
    sda_m <= BUS.sda;
    sda_s <= sda_m;
    strap_m <= ADDR_STRAP_PINS;
    strap_s <= strap_m;
    guard_m <= WRITE_GUARD_N;
    guard_s <= guard_m;
    if (commit) slots[nv_sel] <= nv_data;
    if (RESET) begin
      scl_p <= 1'b1;
      sda_p <= 1'b1;
      st <= pts_pkg::DS_IDLE;
      cnt <= 4'h0;
      byte_idx <= 3'h0;
      sh <= 8'h00;
      rw <= 1'b0;
      op <= 3'h0;
      sel <= 2'h0;
      hold <= 8'h00;
      oe <= 1'b0;
      wiper_position_reg <= slots[`PTS_DEFAULT_SLOT];
      tap <= onehot(slots[`PTS_DEFAULT_SLOT]);
      pend <= 1'b0;
      busy <= 1'b0;
      nv_cnt <= '0;
      nv_data <= '0;
      nv_sel <= 2'h0;
    end else begin
      scl_p <= scl_s;
      sda_p <= sda_s;
      st <= next_st;
      cnt <= next_cnt;
      byte_idx <= next_byte_idx;
      sh <= next_sh;
      rw <= next_rw;
      op <= next_op;
      sel <= next_sel;
      hold <= next_hold;
      oe <= next_oe;
      wiper_position_reg <= next_wiper;
      tap <= next_tap;
      pend <= next_pend;
      busy <= next_busy;
      nv_cnt <= next_nv_cnt;
      nv_data <= next_nv_data;
      nv_sel <= next_nv_sel;
    end
  end

  assign TAP_SEL = tap;
  assign WIPER_POS = wiper_position_reg;
  assign NV_BUSY = busy;
  assign BUS.d_sda_o = 1'b0;
  assign BUS.d_sda_oe = oe;
endmodule : pts_dev
`default_nettype wire

// ==== testbench/pts_bus_asserts.sv ====
// concurrent checks on the two-wire bus between master and slave
`timescale 1ns/1ps
`default_nettype none
module pts_bus_asserts (
  // clock and reset
  input wire logic CLOCK,
  input wire logic RESET,
  // bus signals
  input wire logic m_scl,
  input wire logic m_sda_o,
  input wire logic m_sda_oe,
  input wire logic d_sda_o,
  input wire logic d_sda_oe,
  input wire logic scl,
  input wire logic sda
);
  default clocking @(posedge CLOCK); endclocking
  default disable iff (RESET);

  // scl rises seen since the last start; saturates so reads cannot wrap
  logic [3:0] rises;
  logic [3:0] next_rises;
  logic scl_q;
  logic sda_q;
  logic next_scl_q;
  logic next_sda_q;

  always_comb begin
    next_scl_q = scl;
    next_sda_q = sda;
    next_rises = rises;
    if (RESET) begin
      next_rises = 4'h0;
    end else if (scl && scl_q && sda_q && !sda) begin
      next_rises = 4'h0;
    end else if (scl && !scl_q && rises != 4'hF) begin
      next_rises = rises + 4'h1;
    end
  end

  always_ff @(posedge CLOCK) begin
    scl_q <= next_scl_q;
    sda_q <= next_sda_q;
    rises <= next_rises;
  end

  sequence start_cond;
    scl && $rose(m_sda_oe);
  endsequence
  sequence stop_cond;
    scl && $fell(m_sda_oe);
  endsequence
  sequence low_run;
    (!m_scl) [*3];
  endsequence

  dev_open_drain_a: assert property (d_sda_oe |-> !d_sda_o && !sda)
    else $error("slave drives sda high");
  mst_open_drain_a: assert property (m_sda_oe |-> !m_sda_o && !sda)
    else $error("master drives sda high");
  dev_high_hold_a: assert property (
    scl && $past(scl) |-> $stable(d_sda_oe))
    else $error("slave moved sda while scl high");
  dev_edge_low_a: assert property (
    $changed(d_sda_oe) |-> !scl && !$past(scl))
    else $error("slave moved sda outside scl low phase");
  start_release_a: assert property (start_cond |-> !d_sda_oe)
    else $error("slave holds sda at a start");
  stop_release_a: assert property (stop_cond |-> !d_sda_oe)
    else $error("slave holds sda at a stop");
  ack_after_byte_a: assert property (
    $rose(d_sda_oe) |-> rises >= 4'h8)
    else $error("slave drove sda before eight bits");
  scl_low_span_a: assert property ($fell(m_scl) |=> low_run)
    else $error("scl low phase too short");
endmodule : pts_bus_asserts
`default_nettype wire

// ==== testbench/pot_two_wire_slave_test.sv ====
// self-checking bench: register port drives master and potentiometer slave
`timescale 1ns/1ps
`default_nettype none
`include "pts_defs.svh"
module pot_two_wire_slave_test;
  localparam int NV = 200;
  localparam logic [3:0] TYPE = 4'h6; // arbitrary type code
  logic clock = 1'b0;
  logic reset;
  logic [7:0] addr;
  logic [31:0] wdata;
  logic wstrobe;
  logic rstrobe;
  logic [31:0] rdata;
  logic [1:0] strap;
  logic guard_n;
  logic [1023:0] tap_sel;
  logic [9:0] wiper_pos;
  logic nv_busy;
  int error_cnt = 0;
  int cmp_count = 0;

  initial begin
    forever #2.5 clock = ~clock;
  end

  pts_bus_if pts_bus_if_i ();
  pts_mst pts_mst_i (.CLOCK(clock), .RESET(reset), .ADDR(addr),
    .WDATA(wdata), .WSTROBE(wstrobe), .RSTROBE(rstrobe), .RDATA(rdata),
    .BUS(pts_bus_if_i));
  pts_dev #(.DEV_TYPE(TYPE), .NV_CYC(NV)) pts_dev_i (.CLOCK(clock),
    .RESET(reset), .ADDR_STRAP_PINS(strap), .WRITE_GUARD_N(guard_n),
    .TAP_SEL(tap_sel), .WIPER_POS(wiper_pos), .NV_BUSY(nv_busy),
    .BUS(pts_bus_if_i));
  pts_bus_asserts pts_bus_asserts_i (.CLOCK(clock), .RESET(reset),
    .m_scl(pts_bus_if_i.m_scl), .m_sda_o(pts_bus_if_i.m_sda_o),
    .m_sda_oe(pts_bus_if_i.m_sda_oe), .d_sda_o(pts_bus_if_i.d_sda_o),
    .d_sda_oe(pts_bus_if_i.d_sda_oe), .scl(pts_bus_if_i.scl),
    .sda(pts_bus_if_i.sda));

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : complete_run

  task automatic chk_val(input string what, input logic [9:0] exp,
      input logic [9:0] got);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : chk_val

  task automatic chk_bit(input string what, input logic exp, input logic got);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %b seen %b", what, exp, got);
    end
  endtask : chk_bit

  task automatic chk_tap(input logic [9:0] pos);
    logic [1023:0] exp;
    exp = '0;
    exp[pos] = 1'b1;
    cmp_count++;
    if (tap_sel !== exp) begin
      error_cnt++;
      $display("ERROR tap_sel expected bit %0d seen %h", pos, tap_sel);
    end
  endtask : chk_tap

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    addr <= a;
    wdata <= d;
    wstrobe <= 1'b1;
    @(posedge clock);
    wstrobe <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clock);
    addr <= a;
    rstrobe <= 1'b1;
    @(posedge clock);
    rstrobe <= 1'b0;
    #1;
    d = rdata;
  endtask : rd

  function automatic logic [7:0] idb(input logic [1:0] s, input logic rw);
    return {TYPE, 1'b0, s, rw};
  endfunction : idb

  // one frame through the master, then bounded poll of its busy flag
  task automatic run(input logic [7:0] id, input logic [7:0] cmd,
      input logic [9:0] d, input logic [2:0] ctl, output logic nack);
    logic [31:0] st;
    int n;
    wr(`PTS_REG_ID, {24'h000000, id});
    wr(`PTS_REG_CMD, {24'h000000, cmd});
    wr(`PTS_REG_WDATA, {22'h000000, d});
    wr(`PTS_REG_CTRL, {29'h00000000, ctl});
    n = 0;
    st = 32'h00000001;
    while (st[`PTS_STAT_BUSY] !== 1'b0 && n < 2000) begin
      rd(`PTS_REG_STATUS, st);
      n++;
    end
    if (n >= 2000) begin
      error_cnt++;
      $display("ERROR master_busy expected 0 seen 1");
      complete_run();
    end
    nack = st[`PTS_STAT_NACK];
  endtask : run

  // the write may take twice its typical time at most
  task automatic wait_nv();
    int n;
    n = 0;
    while (nv_busy !== 1'b0 && n < 2 * NV) begin
      @(posedge clock);
      n++;
    end
    if (n >= 2 * NV) begin
      error_cnt++;
      $display("ERROR nv_busy expected 0 seen 1");
      complete_run();
    end
    repeat (4) @(posedge clock);
  endtask : wait_nv

  initial begin
    logic nk;
    logic [31:0] v;
    int i;
    reset = 1'b1;
    addr = 8'h00;
    wdata = 32'h00000000;
    wstrobe = 1'b0;
    rstrobe = 1'b0;
    strap = 2'h2;
    guard_n = 1'b1;
    repeat (8) @(posedge clock);
    reset <= 1'b0;
    #1;
    chk_val("wiper_pos", 10'h000, wiper_pos);
    chk_tap(10'h000);
    $display("test reset done");
    run(idb(strap, 1'b0), 8'hA0, 10'h2A5, 3'h5, nk);
    chk_bit("nack", 1'b0, nk);
    chk_val("wiper_pos", 10'h2A5, wiper_pos);
    chk_tap(10'h2A5);
    run(idb(strap, 1'b1), 8'h80, 10'h000, 3'h5, nk);
    rd(`PTS_REG_RDATA, v);
    chk_val("wiper_read", 10'h2A5, v[9:0]);
    $display("test wiper done");
    run(idb(strap, 1'b0), 8'hC8, 10'h155, 3'h5, nk);
    chk_bit("nv_busy", 1'b1, nv_busy);
    run(idb(strap, 1'b0), 8'h00, 10'h000, 3'h3, nk);
    chk_bit("poll_busy", 1'b1, nk);
    wait_nv();
    run(idb(strap, 1'b0), 8'h00, 10'h000, 3'h3, nk);
    chk_bit("poll_done", 1'b0, nk);
    run(idb(strap, 1'b1), 8'hA8, 10'h000, 3'h5, nk);
    rd(`PTS_REG_RDATA, v);
    chk_val("slot_read", 10'h155, v[9:0]);
    run(idb(strap, 1'b1), 8'hC8, 10'h000, 3'h1, nk);
    chk_val("wiper_xfr", 10'h155, wiper_pos);
    $display("test slots done");
    @(posedge clock);
    guard_n <= 1'b0;
    repeat (4) @(posedge clock);
    run(idb(strap, 1'b0), 8'hCC, 10'h3FF, 3'h5, nk);
    wait_nv();
    guard_n <= 1'b1;
    repeat (4) @(posedge clock);
    run(idb(strap, 1'b1), 8'hAC, 10'h000, 3'h5, nk);
    rd(`PTS_REG_RDATA, v);
    chk_val("guarded_slot", 10'h000, v[9:0]);
    $display("test guard done");
    for (i = 0; i < 4; i++) begin
      @(posedge clock);
      strap <= i[1:0];
      repeat (4) @(posedge clock);
      run(idb(i[1:0], 1'b0), 8'h00, 10'h000, 3'h3, nk);
      chk_bit("strap_match", 1'b0, nk);
      run(idb(i[1:0] + 2'h1, 1'b0), 8'h00, 10'h000, 3'h3, nk);
      chk_bit("strap_miss", 1'b1, nk);
    end
    run({TYPE, 1'b1, strap, 1'b0}, 8'h00, 10'h000, 3'h3, nk);
    chk_bit("id_bit3", 1'b1, nk);
    run({~TYPE, 1'b0, strap, 1'b0}, 8'h00, 10'h000, 3'h3, nk);
    chk_bit("id_type", 1'b1, nk);
    run(idb(strap, 1'b0), 8'hA1, 10'h0AA, 3'h5, nk);
    chk_bit("bad_cmd", 1'b1, nk);
    chk_val("wiper_kept", 10'h155, wiper_pos);
    $display("test addressing done");
    run(idb(strap, 1'b0), 8'hE0, 10'h000, 3'h1, nk);
    chk_bit("nv_busy", 1'b1, nv_busy);
    wait_nv();
    run(idb(strap, 1'b0), 8'hA0, 10'h2A5, 3'h5, nk);
    @(posedge clock);
    reset <= 1'b1;
    repeat (3) @(posedge clock);
    reset <= 1'b0;
    #1;
    chk_val("recall", 10'h155, wiper_pos);
    chk_tap(10'h155);
    $display("test recall done");
    complete_run();
  end
endmodule : pot_two_wire_slave_test
`default_nettype wire
